// file: rtl/asr_rx.sv
/*
 * Asynchronous serial receiver with register port, optional flow
 * control pin, parity check and millisecond timeout.
 * Assumes one 50 MHz clock, a synchronous reset and a serial pin that
 * arrives from outside the clock domain.
 */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "asr_defines.svh"

module asr_rx import asr_pkg::*; #(
    parameter int CYC_PER_US = `ASR_NS_PER_US / `ASR_CLK_NS,
    parameter int US_PER_MS  = `ASR_US_PER_MS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wstb,
    input  wire logic        rstb,
    output var  logic [31:0] rdata,
    // Serial receive pin
    input  wire logic        rx_pin_i,
    output var  logic        rx_pin_o,
    output var  logic        rx_pin_oe_n,
    // Flow control pin
    output var  logic        fc_pin_o,
    output var  logic        fc_pin_oe_n,
    // Consumer side
    output var  logic [7:0]  rx_data,
    output var  logic [7:0]  rx_idx,
    output var  logic        rx_valid
);

    asr_regs_s q;
    asr_regs_s d;
    logic      line;

    // Bit period in clock cycles from the configuration word
    function automatic logic [17:0] per(input logic [15:0] c);
        per = 18'((int'(c[`ASR_CFG_PER_HI:0]) + `ASR_BIT_OFS_US)
                  * CYC_PER_US);
    endfunction

    assign line = q.s2 ^ q.cfg[`ASR_CFG_INV];

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d          = q;
        d.s1       = rx_pin_i;
        d.s2       = q.s1;
        d.rx_valid = 1'b0;
        d.rdata    = '0;
        d.rx_o     = 1'b0;
        d.rx_oe_n  = 1'b1;

        if (wstb && !q.busy) begin
            case (addr)
                `ASR_A_CFG: begin
                    d.cfg = wdata[15:0];
                end
                `ASR_A_TMO: begin
                    d.tmo = wdata[15:0];
                end
                `ASR_A_CTRL: begin
                    if (wdata[`ASR_CTRL_GO]) begin
                        d.busy = 1'b1;
                        d.done = 1'b0;
                        d.perr = 1'b0;
                        d.tout = 1'b0;
                        d.got  = '0;
                        d.want = wdata[`ASR_CTRL_CNT_HI:`ASR_CTRL_CNT_LO];
                        if (d.want == 8'h00) begin
                            d.want = 8'h01;
                        end
                        d.flow = wdata[`ASR_CTRL_FLOW];
                        d.st   = ASR_WAIT;
                        d.us   = '0;
                        d.msu  = '0;
                        d.ms   = '0;
                        if (wdata[`ASR_CTRL_FLOW]) begin
                            d.fc_oe_n = 1'b0;
                            d.fc      = q.cfg[`ASR_CFG_INV];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (rstb) begin
            case (addr)
                `ASR_A_CFG:  d.rdata = {16'h0000, q.cfg};
                `ASR_A_TMO:  d.rdata = {16'h0000, q.tmo};
                `ASR_A_CTRL: d.rdata = {16'h0000, q.want, 6'h00, q.flow,
                                        1'b0};
                `ASR_A_STAT: d.rdata = {16'h0000, q.got, 4'h0, q.tout,
                                        q.perr, q.done, q.busy};
                `ASR_A_DATA: d.rdata = {24'h000000, q.rx_data};
                default:     d.rdata = '0;
            endcase
        end

        case (q.st)
            ASR_IDLE: begin
            end
            ASR_WAIT: begin
                if (!line) begin
                    d.st   = ASR_START;
                    d.bcnt = 18'((per(q.cfg) >> 1) - 18'h00001);
                end else if (q.tmo != 16'h0000) begin
                    if (q.us == 8'(CYC_PER_US - 1)) begin
                        d.us = '0;
                        if (q.msu == 10'(US_PER_MS - 1)) begin
                            d.msu = '0;
                            d.ms  = q.ms + 16'h0001;
                            if (q.ms + 16'h0001 == q.tmo) begin
                                d.tout = 1'b1;
                                d.busy = 1'b0;
                                d.done = 1'b1;
                                d.st   = ASR_IDLE;
                                d.fc   = ~q.cfg[`ASR_CFG_INV];
                            end
                        end else begin
                            d.msu = q.msu + 10'h001;
                        end
                    end else begin
                        d.us = q.us + 8'h01;
                    end
                end
            end
            ASR_START: begin
                if (q.bcnt != '0) begin
                    d.bcnt = q.bcnt - 18'h00001;
                end else if (line) begin
                    d.st = ASR_WAIT;
                end else begin
                    d.st   = ASR_DATA;
                    d.bcnt = per(q.cfg) - 18'h00001;
                    d.nbit = '0;
                end
            end
            ASR_DATA: begin
                if (q.bcnt != '0) begin
                    d.bcnt = q.bcnt - 18'h00001;
                end else begin
                    d.sh   = {line, q.sh[7:1]};
                    d.bcnt = per(q.cfg) - 18'h00001;
                    d.nbit = q.nbit + 3'h1;
                    if (q.nbit == 3'h7) begin
                        d.st = ASR_STOP;
                    end
                end
            end
            ASR_STOP: begin
                if (q.bcnt != '0) begin
                    d.bcnt = q.bcnt - 18'h00001;
                end else if (q.cfg[`ASR_CFG_FMT] && ^q.sh) begin
                    d.perr = 1'b1;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.st   = ASR_IDLE;
                    d.fc   = ~q.cfg[`ASR_CFG_INV];
                end else begin
                    d.rx_valid = 1'b1;
                    d.rx_idx   = q.got;
                    d.rx_data  = q.cfg[`ASR_CFG_FMT] ?
                                 {1'b0, q.sh[6:0]} : q.sh;
                    d.got      = q.got + 8'h01;
                    d.us       = '0;
                    d.msu      = '0;
                    d.ms       = '0;
                    if (q.got + 8'h01 == q.want) begin
                        d.busy = 1'b0;
                        d.done = 1'b1;
                        d.st   = ASR_IDLE;
                        d.fc   = ~q.cfg[`ASR_CFG_INV];
                    end else begin
                        d.st = ASR_WAIT;
                    end
                end
            end
            default: begin
                d.st = ASR_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q         <= '0;
            q.s1      <= 1'b1;  // Idle pin level: no false start
            q.s2      <= 1'b1;
            q.cfg     <= `ASR_CFG_RST;
            q.tmo     <= `ASR_TMO_RST;
            q.rx_oe_n <= 1'b1;
            q.fc      <= 1'b1;
            q.fc_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdata       = q.rdata;
    assign rx_pin_o    = q.rx_o;
    assign rx_pin_oe_n = q.rx_oe_n;
    assign fc_pin_o    = q.fc;
    assign fc_pin_oe_n = q.fc_oe_n;
    assign rx_data     = q.rx_data;
    assign rx_idx      = q.rx_idx;
    assign rx_valid    = q.rx_valid;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_rx_pin_input: assert property (
        q.busy |-> q.rx_oe_n && !q.rx_o)
        else $error("receive pin driven during reception");

    a_flow_go_level: assert property (
        (q.busy && q.flow) |->
            (!q.fc_oe_n && q.fc == q.cfg[`ASR_CFG_INV]))
        else $error("flow pin not at go level while receiving");

    a_flow_stop_level: assert property (
        ($fell(q.busy) && q.flow) |->
            (!q.fc_oe_n && q.fc == !q.cfg[`ASR_CFG_INV]))
        else $error("flow pin not at stop level after reception");

    a_cfg_write: assert property (
        (wstb && addr == `ASR_A_CFG && !q.busy) |=>
            q.cfg == $past(wdata[15:0]))
        else $error("configuration word not taken");

    a_bit_period: assert property (
        (q.st == ASR_DATA && $past(q.st) == ASR_START) |->
            q.bcnt == per(q.cfg) - 18'h00001)
        else $error("bit period load wrong");

    a_parity_abort: assert property (
        (q.st == ASR_STOP && q.bcnt == '0 && q.cfg[`ASR_CFG_FMT]
         && ^q.sh) |=> (q.perr && !q.busy && !q.rx_valid))
        else $error("parity mismatch not aborted");

    a_seven_bit_msb: assert property (
        (q.rx_valid && q.cfg[`ASR_CFG_FMT]) |-> !q.rx_data[7])
        else $error("top bit set in parity mode");

    a_timeout_cause: assert property (
        $rose(q.tout) |->
            ($past(q.st) == ASR_WAIT && q.tmo != 16'h0000))
        else $error("timeout without armed wait");

    a_valid_order: assert property (
        q.rx_valid |-> (q.got == q.rx_idx + 8'h01) ##1 !q.rx_valid)
        else $error("delivery order broken");

    a_rx_pin_idle: assert property (
        !q.busy |-> (q.rx_oe_n && !q.rx_o))
        else $error("receive pin driven while idle");

    a_flow_enable: assert property (
        $fell(q.fc_oe_n) |-> (q.busy && q.flow))
        else $error("flow pin enabled without flow start");

    a_cfg_locked: assert property (
        q.busy |=> $stable(q.cfg))
        else $error("configuration changed during reception");

    a_tmo_write: assert property (
        (wstb && addr == `ASR_A_TMO && !q.busy) |=>
            q.tmo == $past(wdata[15:0]))
        else $error("timeout value not taken");

    a_start_load: assert property (
        (q.st == ASR_START && $past(q.st) == ASR_WAIT) |->
            q.bcnt == (per(q.cfg) >> 1) - 18'h00001)
        else $error("half period load wrong");

    a_eight_samples: assert property (
        (q.st == ASR_STOP && $past(q.st) == ASR_DATA) |->
            (q.nbit == 3'h0 && q.bcnt == per(q.cfg) - 18'h00001))
        else $error("data bit count or stop wait wrong");

    a_low_bits: assert property (
        q.rx_valid |-> q.rx_data[6:0] == q.sh[6:0])
        else $error("delivered low bits differ from shifted bits");

    a_top_bit_8n: assert property (
        (q.rx_valid && !q.cfg[`ASR_CFG_FMT]) |-> q.rx_data[7] == q.sh[7])
        else $error("top data bit lost in eight bit format");

    a_parity_even: assert property (
        (q.rx_valid && q.cfg[`ASR_CFG_FMT]) |-> !(^q.sh))
        else $error("byte delivered with odd parity");

    a_timeout_ms: assert property (
        $rose(q.tout) |-> q.ms == q.tmo)
        else $error("timeout before the set milliseconds");

    a_ms_bound: assert property (
        (q.st == ASR_WAIT && q.tmo != 16'h0000) |->
            q.ms < q.tmo)
        else $error("millisecond count past timeout");

    a_end_idle: assert property (
        $fell(q.busy) |-> (q.done && q.st == ASR_IDLE))
        else $error("reception ended without done");

    a_abort_stop: assert property (
        q.perr |-> !q.busy)
        else $error("busy after parity error");

    a_rdata_quiet: assert property (
        !rstb |=> q.rdata == 32'h00000000)
        else $error("read data without read strobe");

    a_index_clear: assert property (
        $rose(q.busy) |-> q.got == 8'h00)
        else $error("byte index not cleared at start");

    a_start_seen: assert property (
        (q.st == ASR_WAIT && !line) |=> q.st == ASR_START)
        else $error("start edge missed");

    a_false_start: assert property (
        (q.st == ASR_START && q.bcnt == '0 && line) |=>
            q.st == ASR_WAIT)
        else $error("false start not rejected");

    a_period_bound: assert property (
        (q.st == ASR_DATA) |-> q.bcnt < per(q.cfg))
        else $error("bit counter beyond period");

endmodule

`default_nettype wire

// file: rtl/asr_defines.svh
/*
 * Constants of the asynchronous serial receiver: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 50 MHz system clock; included by its bare name.
 */
// Operation
// - The receive pin is only ever an input during reception.
// - With flow control selected, the flow pin is driven as an output.
// - One 16-bit configuration word sets the whole line format.
// - Bits 0..11 give the bit period: 1e6/baud minus 20 microseconds.
// - Bit 13 clear: 8 data bits; set: 7 data bits plus even parity.
// - Bit 14 clear: true line levels; set: inverted line levels.
// - Each frame has exactly one stop bit.
// - Rates from 300 to 38400 baud are supported.
// - A parity mismatch aborts reception and reports a parity error.
// - A nonzero timeout up to 65535 aborts a wait with a timeout flag.
// - Received words go to the consumer in arrival order, indexed.
// - Timing is recovered from the data line alone, no clock line.
// - Both ends use the same timing, format and polarity.
// - Even parity: ones over data and parity bit count even.
// - The timeout counts milliseconds of waiting for data.
// - Flow pin go/stop levels are low/high, swapped when inverted.
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

`define ASR_CLK_NS      20
`define ASR_NS_PER_US   1000
`define ASR_US_PER_MS   1000
`define ASR_BIT_OFS_US  20
`define ASR_BAUD_MIN    300
`define ASR_BAUD_MAX    38400

`define ASR_CFG_PER_HI  11
`define ASR_CFG_FMT     13
`define ASR_CFG_INV     14
`define ASR_CFG_RST     16'h0054
`define ASR_TMO_RST     16'h0000

`define ASR_A_CFG       8'h00
`define ASR_A_TMO       8'h04
`define ASR_A_CTRL      8'h08
`define ASR_A_STAT      8'h0c
`define ASR_A_DATA      8'h10

`define ASR_CTRL_GO     0
`define ASR_CTRL_FLOW   1
`define ASR_CTRL_CNT_LO 8
`define ASR_CTRL_CNT_HI 15

`endif

// file: rtl/asr_pkg.sv
/*
 * Types of the asynchronous serial receiver: receiver states and the
 * packed state record of the receiver module.
 * Assumes nothing of its surroundings.
 */
package asr_pkg;

    typedef enum logic [2:0] {
        ASR_IDLE,
        ASR_WAIT,
        ASR_START,
        ASR_DATA,
        ASR_STOP
    } asr_state_e;

    typedef struct packed {
        asr_state_e  st;
        logic        s1;
        logic        s2;
        logic [15:0] cfg;
        logic [15:0] tmo;
        logic        flow;
        logic [7:0]  want;
        logic [7:0]  got;
        logic [17:0] bcnt;
        logic [7:0]  us;
        logic [9:0]  msu;
        logic [15:0] ms;
        logic [2:0]  nbit;
        logic [7:0]  sh;
        logic        busy;
        logic        done;
        logic        perr;
        logic        tout;
        logic [31:0] rdata;
        logic [7:0]  rx_data;
        logic [7:0]  rx_idx;
        logic        rx_valid;
        logic        rx_o;
        logic        rx_oe_n;
        logic        fc;
        logic        fc_oe_n;
    } asr_regs_s;

endpackage

// file: sim/asr_sender.sv
/*
 * Remote serial sender model: one frame per go pulse.
 * Assumes the bench holds din, par_en, inv, bad_par and per steady.
 */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Sender
module asr_sender (
    // Clock
    input  wire logic        clk,
    // Frame request
    input  wire logic        go,
    input  wire logic [7:0]  din,
    input  wire logic        par_en,
    input  wire logic        inv,
    input  wire logic        bad_par,
    input  wire logic [15:0] per,
    // Data line only, no clock line
    output var  logic        line
);
    logic       lvl = 1'b1;
    logic [9:0] frame;

    assign line = lvl ^ inv;

    always begin
        @(posedge clk);
        if (go) begin
            frame = {1'b1, din, 1'b0};
            if (par_en) begin
                frame[8] = ^din[6:0] ^ bad_par;
            end
            for (int i = 0; i < 10; i++) begin
                lvl <= frame[i];
                repeat (per) @(posedge clk);
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/async_serial_receiver_tb.sv
/*
 * Self-checking bench of the serial receiver.
 * Assumes the receiver and the sender model; rtl/ on the include path.
 */
`timescale 1ns/100ps
`default_nettype none
`include "asr_defines.svh"
// ==========================================
// Bench
module async_serial_receiver_tb;
    localparam int CPU = 2;
    localparam int UPM = 4;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wstb = 1'b0;
    logic        rstb = 1'b0;
    logic [31:0] rdata;
    logic        rx_pin_i;
    logic        rx_pin_o;
    logic        rx_pin_oe_n;
    logic        fc_pin_o;
    logic        fc_pin_oe_n;
    logic [7:0]  rx_data;
    logic [7:0]  rx_idx;
    logic        rx_valid;
    logic        go = 1'b0;
    logic        par_en = 1'b0;
    logic        inv = 1'b0;
    logic        bad = 1'b0;
    logic [7:0]  din = 8'h00;
    logic [15:0] per = 16'd48;
    logic [15:0] exp_q[$];
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          seed = 32'h6ad8;

    asr_rx #(.CYC_PER_US(CPU), .US_PER_MS(UPM)) uut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wstb(wstb), .rstb(rstb), .rdata(rdata), .rx_pin_i(rx_pin_i),
        .rx_pin_o(rx_pin_o), .rx_pin_oe_n(rx_pin_oe_n), .fc_pin_o(fc_pin_o),
        .fc_pin_oe_n(fc_pin_oe_n), .rx_data(rx_data), .rx_idx(rx_idx),
        .rx_valid(rx_valid)
    );
    asr_sender partner (
        .clk(clk), .go(go), .din(din), .par_en(par_en), .inv(inv),
        .bad_par(bad), .per(per), .line(rx_pin_i)
    );

    initial begin
        forever #10 clk = ~clk;
    end
// ==========================================
// Tasks
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= {16'h0, d};
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] v;
        rd(a, v);
        check($sformatf("reg_%h", a), v, {16'h0, e});
    endtask

    task automatic wait_idle();
        logic [31:0] v;
        for (int i = 0; i < 400; i++) begin
            rd(`ASR_A_STAT, v);
            if (v[0] === 1'b0) break;
        end
    endtask

    task automatic send(input logic [7:0] d);
        din <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (10 * per + 4) @(posedge clk);
    endtask

    task automatic rx_op(input logic [15:0] cfg, input int n,
                         input logic b, input logic [15:0] st);
        logic [7:0] d;
        logic [7:0] e;
        inv <= cfg[14];
        par_en <= cfg[13];
        bad <= b;
        per <= 16'((cfg[11:0] + 12'd20) * CPU);
        wr(`ASR_A_CFG, cfg);
        wr(`ASR_A_TMO, 16'h0);
        repeat (3) @(posedge clk);
        wr(`ASR_A_CTRL, {n[7:0], 8'h03});
        wr(`ASR_A_CFG, 16'h0055);
        #1;
        check("fc_oe_n", {31'h0, fc_pin_oe_n}, 32'h0);
        check("fc_go", {31'h0, fc_pin_o}, {31'h0, cfg[14]});
        check("rx_oe_n", {31'h0, rx_pin_oe_n}, 32'h1);
        check("rx_o", {31'h0, rx_pin_o}, 32'h0);
        rchk(`ASR_A_CTRL, {n[7:0], 8'h02});
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            e = cfg[13] ? {1'b0, d[6:0]} : d;
            if (!b) exp_q.push_back({i[7:0], e});
            send(d);
        end
        wait_idle();
        rchk(`ASR_A_STAT, st);
        rchk(`ASR_A_CFG, cfg);
        if (!b) rchk(`ASR_A_DATA, {8'h0, e});
        check("fc_stop", {31'h0, fc_pin_o}, {31'h0, ~cfg[14]});
    endtask
// ==========================================
// Result watcher and timeout
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("rx_extra", 32'h1, 32'h0);
            else
                check("rx_word", {16'h0, rx_idx, rx_data},
                      {16'h0, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
// ==========================================
// Main sequence
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        check("fc_oe_n_rst", {31'h0, fc_pin_oe_n}, 32'h1);
        rchk(`ASR_A_CFG, 16'h0054);
        rchk(`ASR_A_TMO, 16'h0000);
        rchk(8'h14, 16'h0000);
        $display("test reset done");
        rx_op(16'h0004, 3, 1'b0, 16'h0302);
        $display("test 8n true done");
        rx_op(16'h600a, 2, 1'b0, 16'h0202);
        $display("test 7e inverted done");
        rx_op(16'h2004, 1, 1'b1, 16'h0006);
        $display("test parity error done");
        wr(`ASR_A_TMO, 16'h0002);
        wr(`ASR_A_CTRL, 16'h0001);
        repeat (8) @(posedge clk);
        rchk(`ASR_A_STAT, 16'h0001);
        wait_idle();
        rchk(`ASR_A_STAT, 16'h000a);
        check("queue_left", exp_q.size(), 32'h0);
        $display("test timeout done");
        finish_test();
    end
endmodule
`default_nettype wire
